// ===== hw/exec_pkg.sv
// constants and opcode enumeration for the branch and bit-operation execute unit
// assumes a single core clock; the decoder outside hands over one opcode per issue
package exec_pkg;

   // datapath widths
   localparam int PC_W      = 16;
   localparam int DATA_W    = 8;
   localparam int K_W       = 7;
   localparam int BIT_W     = 3;
   localparam int IO_ADDR_W = 5;

   // status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // reset values and fixed steps
   localparam logic [PC_W-1:0]   PC_RESET    = 16'h0000;
   localparam logic [PC_W-1:0]   PC_STEP     = 16'h0001;
   localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
   localparam logic [DATA_W-1:0] BIT_ONE     = 8'h01;

   // operations handled by this unit
   typedef enum logic [4:0] {
      op_nop,
      branch_if_equal,
      branch_if_not_equal,
      branch_on_carry_one,
      branch_on_carry_zero,
      branch_same_or_higher,
      branch_lower_unsigned,
      branch_if_minus,
      branch_if_plus,
      branch_signed_ge,
      branch_signed_less,
      branch_half_carry_one,
      branch_half_carry_zero,
      branch_overflow_zero,
      branch_irq_enabled,
      branch_irq_disabled,
      set_io_bit,
      clear_io_bit,
      shift_left_logical,
      shift_right_logical,
      rotate_left_through_carry,
      rotate_right_through_carry,
      arithmetic_shift_right,
      swap_nibbles,
      flag_set,
      flag_clear,
      store_bit_to_transfer_flag,
      load_bit_from_transfer_flag,
      global_irq_enable
   } op_e;

endpackage

// ===== hw/branch_and_bit_op_execute.sv
// execute unit for conditional relative branches and the bit / bit-test group
// assumes the decoder drives op and operands on the core clock and holds them
// only in the issue cycle; io_rdata is the current value of the addressed port
`timescale 1ns/1ns
`default_nettype none

module branch_and_bit_op_execute (
   input  wire logic                                  sys_clk,
   input  wire logic                                  nrst,
   input  wire logic                                  issue,
   input  wire exec_pkg::op_e                         op,
   input  wire logic [exec_pkg::K_W-1:0]              offset_k,
   input  wire logic [exec_pkg::BIT_W-1:0]            bit_sel,
   input  wire logic [exec_pkg::DATA_W-1:0]           reg_data,
   input  wire logic [exec_pkg::IO_ADDR_W-1:0]        io_addr,
   input  wire logic [exec_pkg::DATA_W-1:0]           io_rdata,
   output logic      [exec_pkg::PC_W-1:0]             prog_counter,
   output logic      [exec_pkg::DATA_W-1:0]           status_flags,
   output logic      [exec_pkg::DATA_W-1:0]           result_data,
   output logic                                       result_we,
   output logic      [exec_pkg::IO_ADDR_W-1:0]        io_waddr,
   output logic      [exec_pkg::DATA_W-1:0]           io_wdata,
   output logic                                       io_we,
   output logic                                       busy,
   output logic                                       done
);

   typedef enum logic [0:0] {st_idle, st_finish} state_e;

   state_e                              state_reg;
   logic [exec_pkg::PC_W-1:0]           pc_reg;
   logic [exec_pkg::PC_W-1:0]           target_reg;
   logic [exec_pkg::DATA_W-1:0]         status_flags_reg;
   logic [exec_pkg::DATA_W-1:0]         status_flags_next;
   logic [exec_pkg::DATA_W-1:0]         result_reg;
   logic [exec_pkg::DATA_W-1:0]         result_next;
   logic                                result_we_reg;
   logic                                writes_reg_next;
   logic [exec_pkg::IO_ADDR_W-1:0]      io_waddr_reg;
   logic [exec_pkg::DATA_W-1:0]         io_wdata_reg;
   logic                                io_we_reg;
   logic                                done_reg;
   logic                                accept;
   logic                                is_branch;
   logic                                cond_met;
   logic                                shift_carry;
   logic [exec_pkg::DATA_W-1:0]         bit_mask;
   logic [exec_pkg::PC_W-1:0]           jump_target;
   logic                                io_op;
   logic                                two_cycle;
   logic                                io_pend_reg;

   assign prog_counter = pc_reg;
   assign status_flags = status_flags_reg;
   assign result_data  = result_reg;
   assign result_we    = result_we_reg;
   assign io_waddr     = io_waddr_reg;
   assign io_wdata     = io_wdata_reg;
   assign io_we        = io_we_reg;
   assign busy         = (state_reg == st_finish);
   assign done         = done_reg;

   ////////////////////////////////////////////////////////////////////////////
   // issue acceptance and branch condition

   // a request during the second cycle of a two-cycle op is ignored
   assign accept    = issue && (state_reg == st_idle);
   assign bit_mask  = exec_pkg::BIT_ONE << bit_sel;
   assign io_op     = op inside {exec_pkg::set_io_bit, exec_pkg::clear_io_bit};
   assign two_cycle = (is_branch && cond_met) || io_op;

   assign jump_target = pc_reg
                      + {{(exec_pkg::PC_W-exec_pkg::K_W){offset_k[exec_pkg::K_W-1]}}, offset_k}
                      + exec_pkg::PC_STEP;

   // flag test for every branch form
   always_comb begin
      is_branch = 1'b1;
      cond_met  = 1'b0;
      unique case (op)
         exec_pkg::branch_if_equal:        cond_met = status_flags_reg[exec_pkg::FLAG_Z];
         exec_pkg::branch_if_not_equal:    cond_met = !status_flags_reg[exec_pkg::FLAG_Z];
         exec_pkg::branch_on_carry_one,
         exec_pkg::branch_lower_unsigned:  cond_met = status_flags_reg[exec_pkg::FLAG_C];
         exec_pkg::branch_on_carry_zero,
         exec_pkg::branch_same_or_higher:  cond_met = !status_flags_reg[exec_pkg::FLAG_C];
         exec_pkg::branch_if_minus:        cond_met = status_flags_reg[exec_pkg::FLAG_N];
         exec_pkg::branch_if_plus:         cond_met = !status_flags_reg[exec_pkg::FLAG_N];
         exec_pkg::branch_signed_ge:       cond_met = !(status_flags_reg[exec_pkg::FLAG_N]
                                                      ^ status_flags_reg[exec_pkg::FLAG_V]);
         exec_pkg::branch_signed_less:     cond_met = status_flags_reg[exec_pkg::FLAG_N]
                                                    ^ status_flags_reg[exec_pkg::FLAG_V];
         exec_pkg::branch_half_carry_one:  cond_met = status_flags_reg[exec_pkg::FLAG_H];
         exec_pkg::branch_half_carry_zero: cond_met = !status_flags_reg[exec_pkg::FLAG_H];
         exec_pkg::branch_overflow_zero:   cond_met = !status_flags_reg[exec_pkg::FLAG_V];
         exec_pkg::branch_irq_enabled:     cond_met = status_flags_reg[exec_pkg::FLAG_I];
         exec_pkg::branch_irq_disabled:    cond_met = !status_flags_reg[exec_pkg::FLAG_I];
         default:               is_branch = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // register-operand datapath and flag update

   // shifts share the z n v derivation, swap and bit load touch no flag
   always_comb begin
      status_flags_next = status_flags_reg;
      result_next       = reg_data;
      writes_reg_next   = 1'b0;
      shift_carry       = 1'b0;
      unique case (op)
         exec_pkg::shift_left_logical: begin
            result_next = {reg_data[exec_pkg::DATA_W-2:0], 1'b0};
            shift_carry = reg_data[exec_pkg::DATA_W-1];
         end
         exec_pkg::shift_right_logical: begin
            result_next = {1'b0, reg_data[exec_pkg::DATA_W-1:1]};
            shift_carry = reg_data[0];
         end
         exec_pkg::rotate_left_through_carry: begin
            result_next = {reg_data[exec_pkg::DATA_W-2:0], status_flags_reg[exec_pkg::FLAG_C]};
            shift_carry = reg_data[exec_pkg::DATA_W-1];
         end
         exec_pkg::rotate_right_through_carry: begin
            result_next = {status_flags_reg[exec_pkg::FLAG_C], reg_data[exec_pkg::DATA_W-1:1]};
            shift_carry = reg_data[0];
         end
         exec_pkg::arithmetic_shift_right: begin
            result_next = {reg_data[exec_pkg::DATA_W-1], reg_data[exec_pkg::DATA_W-1:1]};
            shift_carry = reg_data[0];
         end
         exec_pkg::swap_nibbles: begin
            result_next     = {reg_data[3:0], reg_data[exec_pkg::DATA_W-1:4]};
            writes_reg_next = 1'b1;
         end
         exec_pkg::flag_set:   status_flags_next = status_flags_reg | bit_mask;
         exec_pkg::flag_clear: status_flags_next = status_flags_reg & ~bit_mask;
         exec_pkg::store_bit_to_transfer_flag:
            status_flags_next[exec_pkg::FLAG_T] = reg_data[bit_sel];
         exec_pkg::load_bit_from_transfer_flag: begin
            result_next = status_flags_reg[exec_pkg::FLAG_T] ? (reg_data | bit_mask)
                                                               : (reg_data & ~bit_mask);
            writes_reg_next = 1'b1;
         end
         exec_pkg::global_irq_enable: status_flags_next[exec_pkg::FLAG_I] = 1'b1;
         default: ;
      endcase
      if (op inside {exec_pkg::shift_left_logical, exec_pkg::shift_right_logical,
                     exec_pkg::rotate_left_through_carry, exec_pkg::rotate_right_through_carry,
                     exec_pkg::arithmetic_shift_right}) begin
         writes_reg_next                     = 1'b1;
         status_flags_next[exec_pkg::FLAG_C] = shift_carry;
         status_flags_next[exec_pkg::FLAG_Z] = (result_next == exec_pkg::DATA_ZERO);
         status_flags_next[exec_pkg::FLAG_N] = result_next[exec_pkg::DATA_W-1];
         status_flags_next[exec_pkg::FLAG_V] = result_next[exec_pkg::DATA_W-1] ^ shift_carry;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= st_idle;
      end else if (accept && two_cycle) begin
         state_reg <= st_finish;
      end else begin
         state_reg <= st_idle;
      end
   end

   // done pulses in the cycle after the last cycle of every op
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (state_reg == st_finish) || (accept && !two_cycle);
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pc_reg     <= exec_pkg::PC_RESET;
         target_reg <= exec_pkg::PC_RESET;
      end else if (state_reg == st_finish) begin
         pc_reg <= target_reg;
      end else if (accept) begin
         // fall-through target held for the io ops, jump target for taken branches
         target_reg <= (is_branch && cond_met) ? jump_target : pc_reg + exec_pkg::PC_STEP;
         if (!two_cycle) begin
            pc_reg <= pc_reg + exec_pkg::PC_STEP;
         end
      end
   end

   // branches and io ops leave the flags alone through the default path
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_flags_reg <= exec_pkg::FLAGS_RESET;
      end else if (accept) begin
         status_flags_reg <= status_flags_next;
      end
   end

   // register write-back, one-cycle strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         result_reg    <= exec_pkg::DATA_ZERO;
         result_we_reg <= 1'b0;
      end else begin
         result_we_reg <= accept && writes_reg_next;
         if (accept && writes_reg_next) begin
            result_reg <= result_next;
         end
      end
   end

   // read-modify-write of the port
   // the port is sampled at issue; a write to it by others in between is lost
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         io_waddr_reg <= '0;
         io_wdata_reg <= exec_pkg::DATA_ZERO;
         io_pend_reg  <= 1'b0;
         io_we_reg    <= 1'b0;
      end else begin
         // strobe trails the issue by two cycles and follows only port ops, not branches
         io_pend_reg <= accept && io_op;
         io_we_reg   <= io_pend_reg;
         if (accept && op == exec_pkg::set_io_bit) begin
            io_waddr_reg <= io_addr;
            io_wdata_reg <= io_rdata | bit_mask;
         end else if (accept && op == exec_pkg::clear_io_bit) begin
            io_waddr_reg <= io_addr;
            io_wdata_reg <= io_rdata & ~bit_mask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_taken_issue;
      accept && is_branch && cond_met;
   endsequence

   sequence s_finish;
      busy && !done ##1 done && !busy;
   endsequence

   property p_carry_jump;
      accept && cond_met && op inside {exec_pkg::branch_on_carry_one,
                                       exec_pkg::branch_lower_unsigned,
                                       exec_pkg::branch_on_carry_zero,
                                       exec_pkg::branch_same_or_higher}
         |-> ##2 pc_reg == $past(jump_target, 2);
   endproperty
   a_carry_jump: assert property (p_carry_jump) else $error("carry branch target wrong");

   property p_ge_fall;
      accept && op == exec_pkg::branch_signed_ge
         && (status_flags_reg[exec_pkg::FLAG_N] ^ status_flags_reg[exec_pkg::FLAG_V])
         |=> done && pc_reg == $past(pc_reg) + exec_pkg::PC_STEP;
   endproperty
   a_ge_fall: assert property (p_ge_fall) else $error("signed ge jumped on n^v one");

   property p_less_fall;
      accept && op == exec_pkg::branch_signed_less
         && !(status_flags_reg[exec_pkg::FLAG_N] ^ status_flags_reg[exec_pkg::FLAG_V])
         |=> done && pc_reg == $past(pc_reg) + exec_pkg::PC_STEP;
   endproperty
   a_less_fall: assert property (p_less_fall) else $error("signed less jumped on n^v zero");

   property p_half_taken;
      accept && op == exec_pkg::branch_half_carry_one && status_flags_reg[exec_pkg::FLAG_H]
         |=> s_finish;
   endproperty
   a_half_taken: assert property (p_half_taken) else $error("half carry branch not taken");

   property p_branch_flags;
      accept && is_branch |=> status_flags_reg == $past(status_flags_reg);
   endproperty
   a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags");

   property p_io_set;
      accept && op == exec_pkg::set_io_bit |=> !io_we ##1 io_we
         && io_wdata == ($past(io_rdata, 2) | $past(bit_mask, 2));
   endproperty
   a_io_set: assert property (p_io_set) else $error("set io bit wrong");

   property p_io_clear;
      accept && op == exec_pkg::clear_io_bit |=> !io_we ##1 io_we
         && io_wdata == ($past(io_rdata, 2) & ~$past(bit_mask, 2));
   endproperty
   a_io_clear: assert property (p_io_clear) else $error("clear io bit wrong");

   property p_rotate_left;
      accept && op == exec_pkg::rotate_left_through_carry |=> result_we
         && result_data == {$past(reg_data[6:0]), $past(status_flags_reg[exec_pkg::FLAG_C])}
         && status_flags_reg[exec_pkg::FLAG_C] == $past(reg_data[7]);
   endproperty
   a_rotate_left: assert property (p_rotate_left) else $error("rotate left wrong");

   property p_asr_sign;
      accept && op == exec_pkg::arithmetic_shift_right |=> result_data[7] == $past(reg_data[7])
         && status_flags_reg[exec_pkg::FLAG_C] == $past(reg_data[0]);
   endproperty
   a_asr_sign: assert property (p_asr_sign) else $error("shift right sign lost");

   property p_store_bit;
      accept && op == exec_pkg::store_bit_to_transfer_flag |=> !result_we
         && status_flags_reg[exec_pkg::FLAG_T] == $past(reg_data[bit_sel]);
   endproperty
   a_store_bit: assert property (p_store_bit) else $error("bit store wrong");

   property p_irq_enable;
      accept && op == exec_pkg::global_irq_enable |=> status_flags_reg[exec_pkg::FLAG_I]
         && status_flags_reg[6:0] == $past(status_flags_reg[6:0]);
   endproperty
   a_irq_enable: assert property (p_irq_enable) else $error("irq enable wrong");

   property p_taken_two;
      s_taken_issue |=> s_finish;
   endproperty
   a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

endmodule

`default_nettype wire

// ===== verif/branch_and_bit_op_execute_test.sv
// self-checking bench for the branch and bit-operation execute unit
// assumes the unit carries its own assertions; the bench models pc and flags itself
`timescale 1ns/1ns
`default_nettype none
module branch_and_bit_op_execute_test;
   logic          sys_clk;
   logic          nrst;
   logic          issue;
   exec_pkg::op_e op;
   logic [6:0]    offset_k;
   logic [2:0]    bit_sel;
   logic [7:0]    reg_data;
   logic [4:0]    io_addr;
   logic [7:0]    io_rdata;
   logic [15:0]   prog_counter;
   logic [7:0]    status_flags;
   logic [7:0]    result_data;
   logic          result_we;
   logic [4:0]    io_waddr;
   logic [7:0]    io_wdata;
   logic          io_we;
   logic          busy;
   logic          done;
   int            num_errors;
   int            num_checks;
   int            cyc;
   logic          busy1;
   logic [7:0]    g_res;
   logic          g_rwe;
   logic          g_iwe;
   logic [4:0]    g_wa;
   logic [7:0]    g_wd;
   logic [15:0]   exp_pc;
   logic [7:0]    exp_fl;
   // branch table: flag index (9 means n xor v) and the level that takes the jump
   exec_pkg::op_e bop [15] = '{exec_pkg::branch_on_carry_one, exec_pkg::branch_on_carry_zero,
      exec_pkg::branch_same_or_higher, exec_pkg::branch_lower_unsigned,
      exec_pkg::branch_signed_ge, exec_pkg::branch_signed_less,
      exec_pkg::branch_half_carry_one, exec_pkg::branch_half_carry_zero,
      exec_pkg::branch_overflow_zero, exec_pkg::branch_irq_enabled,
      exec_pkg::branch_irq_disabled, exec_pkg::branch_if_equal,
      exec_pkg::branch_if_not_equal, exec_pkg::branch_if_minus, exec_pkg::branch_if_plus};
   int            bidx [15] = '{0, 0, 0, 0, 9, 9, 5, 5, 3, 7, 7, 1, 1, 2, 2};
   logic          bpol [15] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1,
      1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [7:0]    fpat [7]  = '{8'h00, 8'hFF, 8'h0C, 8'h04, 8'h08, 8'hA1, 8'h22};
   exec_pkg::op_e sop [5]   = '{exec_pkg::rotate_left_through_carry,
      exec_pkg::rotate_right_through_carry, exec_pkg::arithmetic_shift_right,
      exec_pkg::shift_left_logical, exec_pkg::shift_right_logical};
   logic [7:0]    sdat [4]  = '{8'h80, 8'h01, 8'h81, 8'h7F};

   branch_and_bit_op_execute uut (.sys_clk(sys_clk), .nrst(nrst), .issue(issue), .op(op),
      .offset_k(offset_k), .bit_sel(bit_sel), .reg_data(reg_data), .io_addr(io_addr),
      .io_rdata(io_rdata), .prog_counter(prog_counter), .status_flags(status_flags),
      .result_data(result_data), .result_we(result_we), .io_waddr(io_waddr),
      .io_wdata(io_wdata), .io_we(io_we), .busy(busy), .done(done));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and watchdog; the limit is far above the roughly 1200 cycles needed
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      #40000;
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // issue one op at a falling edge, then count cycles until done under a bound
   task automatic run(input exec_pkg::op_e o, input logic [6:0] k, input logic [2:0] b,
                      input logic [7:0] rd, input logic [7:0] iord, input int n);
      op = o;
      offset_k = k;
      bit_sel = b;
      reg_data = rd;
      io_rdata = iord;
      issue = 1'b1;
      @(negedge sys_clk);
      issue = 1'b0;
      busy1 = busy;
      cyc = 1;
      while (done !== 1'b1 && cyc < 8) begin
         @(negedge sys_clk);
         cyc++;
      end
      g_res = result_data;
      g_rwe = result_we;
      g_iwe = io_we;
      g_wa = io_waddr;
      g_wd = io_wdata;
      check(16'(cyc), 16'(n), "cycle count");
      check({15'h0000, busy1}, {15'h0000, n == 2}, "busy in first cycle");
      check(prog_counter, exp_pc, "program counter");
      check({8'h00, status_flags}, {8'h00, exp_fl}, "status flags");
      // let an edge pass so the next call never raises issue in the step that lowered it
      @(negedge sys_clk);
   endtask

   // load every flag through single-flag set and clear ops
   task automatic set_flags(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         exp_fl[i] = v[i];
         exp_pc = exp_pc + 16'h0001;
         run(v[i] ? exec_pkg::flag_set : exec_pkg::flag_clear, 7'h00, i[2:0], 8'h00, 8'h00, 1);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic       t;
      logic       cn;
      logic [6:0] kk;
      logic [7:0] r;
      nrst = 1'b0;
      issue = 1'b0;
      op = exec_pkg::op_nop;
      offset_k = 7'h00;
      bit_sel = 3'h0;
      reg_data = 8'h00;
      io_addr = 5'h13;
      io_rdata = 8'h00;
      num_errors = 0;
      num_checks = 0;
      exp_pc = 16'h0000;
      exp_fl = 8'h00;
      repeat (5) @(negedge sys_clk);
      check(prog_counter, 16'h0000, "reset pc");
      check({8'h00, status_flags}, 16'h0000, "reset flags");
      check({14'h0000, busy, done}, 16'h0000, "reset strobes");
      nrst = 1'b1;
      @(negedge sys_clk);
      foreach (fpat[p]) begin
         set_flags(fpat[p]);
         foreach (bop[j]) begin
            t = ((bidx[j] == 9) ? exp_fl[2] ^ exp_fl[3] : exp_fl[bidx[j]]) == bpol[j];
            kk = p[0] ? 7'h40 : 7'h3F;
            exp_pc = exp_pc + (t ? {{9{kk[6]}}, kk} + 16'h0001 : 16'h0001);
            run(bop[j], kk, 3'h0, 8'h00, 8'h00, t ? 2 : 1);
         end
      end
      $display("test branches done");
      for (int i = 0; i < 8; i++) begin
         io_addr = 5'h10 + 5'(i);
         exp_pc = exp_pc + 16'h0001;
         run(exec_pkg::set_io_bit, 7'h00, i[2:0], 8'h00, 8'h5A, 2);
         check({g_iwe, g_wa, g_wd}, {1'b1, io_addr, 8'h5A | (8'h01 << i)}, "io set");
         exp_pc = exp_pc + 16'h0001;
         run(exec_pkg::clear_io_bit, 7'h00, i[2:0], 8'h00, 8'hA5, 2);
         check({g_iwe, g_wa, g_wd}, {1'b1, io_addr, 8'hA5 & ~(8'h01 << i)}, "io clear");
      end
      $display("test io bits done");
      foreach (sdat[d]) for (int c = 0; c < 2; c++) for (int s = 0; s < 5; s++) begin
         set_flags(c[0] ? 8'h71 : 8'h70);
         case (s)
            0: begin
               r = {sdat[d][6:0], exp_fl[0]};
               cn = sdat[d][7];
            end
            1: begin
               r = {exp_fl[0], sdat[d][7:1]};
               cn = sdat[d][0];
            end
            3: begin
               r = {sdat[d][6:0], 1'b0};
               cn = sdat[d][7];
            end
            4: begin
               r = {1'b0, sdat[d][7:1]};
               cn = sdat[d][0];
            end
            default: begin
               r = {sdat[d][7], sdat[d][7:1]};
               cn = sdat[d][0];
            end
         endcase
         exp_fl[3:0] = {r[7] ^ cn, r[7], r == 8'h00, cn};
         exp_pc = exp_pc + 16'h0001;
         run(sop[s], 7'h00, 3'h0, sdat[d], 8'h00, 1);
         check({g_rwe, g_res}, {1'b1, r}, "shift result");
      end
      $display("test shifts done");
      for (int i = 0; i < 8; i++) begin
         r = 8'h5A;
         exp_fl[6] = r[i];
         exp_pc = exp_pc + 16'h0001;
         run(exec_pkg::store_bit_to_transfer_flag, 7'h00, i[2:0], r, 8'h00, 1);
         exp_pc = exp_pc + 16'h0001;
         run(exec_pkg::load_bit_from_transfer_flag, 7'h00, i[2:0], 8'hA5, 8'h00, 1);
         check({g_rwe, g_res}, {1'b1, 8'hA5 ^ (8'h01 << i)}, "bit load");
      end
      $display("test transfer flag done");
      set_flags(8'h3C);
      exp_fl[7] = 1'b1;
      exp_pc = exp_pc + 16'h0001;
      run(exec_pkg::global_irq_enable, 7'h00, 3'h0, 8'h00, 8'h00, 1);
      // a taken branch with zero offset lands on pc plus 1 and must not pulse the port write
      exp_pc = exp_pc + 16'h0001;
      run(exec_pkg::branch_irq_enabled, 7'h00, 3'h0, 8'h00, 8'h00, 2);
      check({15'h0000, g_iwe}, 16'h0000, "port write on branch");
      // neighbour ops: swap leaves the flags, no-op only steps the counter
      exp_pc = exp_pc + 16'h0001;
      run(exec_pkg::swap_nibbles, 7'h00, 3'h0, 8'h1E, 8'h00, 1);
      check({g_rwe, g_res}, {1'b1, 8'hE1}, "swap result");
      exp_pc = exp_pc + 16'h0001;
      run(exec_pkg::op_nop, 7'h00, 3'h0, 8'h00, 8'h00, 1);
      check({14'h0000, g_rwe, g_iwe}, 16'h0000, "no-op strobes");
      set_flags(8'h00);
      op = exec_pkg::branch_on_carry_zero;
      offset_k = 7'h02;
      issue = 1'b1;
      @(negedge sys_clk);
      op = exec_pkg::flag_set;
      bit_sel = 3'h2;
      @(negedge sys_clk);
      issue = 1'b0;
      exp_pc = exp_pc + 16'h0003;
      check({15'h0000, done}, 16'h0001, "taken branch done");
      @(negedge sys_clk);
      check(prog_counter, exp_pc, "pc after refused issue");
      check({8'h00, status_flags}, 16'h0000, "flags after refused issue");
      $display("test misc done");
      end_sim();
   end
endmodule
`default_nettype wire
